// ===== ccs_pkg.sv
package ccs_pkg;
  // Machine cycle timing
  localparam int CCS_PERIODS_PER_CYCLE = 12;
  localparam int CCS_STATES_PER_CYCLE = 6;
  localparam int CCS_CLK_MHZ = 40;
  // APB register offsets
  localparam logic [7:0] CCS_OFS_STATUS = 8'h00;
  localparam logic [7:0] CCS_OFS_STACK = 8'h04;
  localparam logic [7:0] CCS_OFS_BREG = 8'h08;
  localparam logic [7:0] CCS_OFS_ACC = 8'h0C;
  localparam logic [7:0] CCS_OFS_SEQ = 8'h10;
  // Reset values
  localparam logic [7:0] CCS_STATUS_RST = 8'h00;
  localparam logic [7:0] CCS_STACK_RST = 8'h07;
  localparam logic [15:0] CCS_PC_RST = 16'h0000;
  // Status word fields
  localparam int CCS_BIT_ODD = 0;
  localparam int CCS_BIT_UF1 = 1;
  localparam int CCS_BIT_SRANGE = 2;
  localparam int CCS_BIT_BANK_LO = 3;
  localparam int CCS_BIT_BANK_HI = 4;
  localparam int CCS_BIT_UF0 = 5;
  localparam int CCS_BIT_HALF = 6;
  localparam int CCS_BIT_CARRY = 7;
  // Overlay window top
  localparam logic [15:0] CCS_OVERLAY_TOP = 16'h0FFF;
  // Instruction classes from the decoder
  typedef enum logic [3:0] {
    CCS_OP_PLAIN1,
    CCS_OP_PLAIN2,
    CCS_OP_LONG1,
    CCS_OP_EXT_MOVE,
    CCS_OP_PRODUCT,
    CCS_OP_QUOTIENT,
    CCS_OP_STACK_STORE,
    CCS_OP_SUB_ENTRY,
    CCS_OP_STACK_LOAD,
    CCS_OP_SUB_EXIT,
    CCS_OP_IRQ_EXIT,
    CCS_OP_ARITH,
    CCS_OP_DECIMAL
  } ccs_op_t;
  localparam int CCS_CYC_PRODUCT = 4;
  localparam int CCS_CYC_EXT_MOVE = 2;
  localparam int CCS_CYC_LONG = 2;
endpackage

// ===== ccs_cpu_cycle_status_stack.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Parity flag makes accumulator ones even
// - Two bank bits select one of four banks
// - Hardware updates carry, half-carry, range flags
// - B register is mul/div operand and result
// - Stack pointer increments before push write
// - Stack pointer decrements after pop read
// - Reset loads stack pointer with 07h
// - Software reads and writes stack pointer
// - Cycle is six states, twelve periods
// - Arithmetic in phase 1, transfers phase 2
// - Address strobe S1P2-S2P1 and S4P2-S5P1
// - Opcode latched at S1P2
// - Second code byte read in S4
// - One-byte S4 fetch discarded, PC held
// - Execution ends at S6P2 of last cycle
// - Product and quotient take four cycles
// - Two code fetches every machine cycle except an external move's second
// - External move skips second-cycle fetches
// - Low 4K routes to boot ROM or memory
// - Register operands resolve to active bank
module ccs_cpu_cycle_status_stack
  import ccs_pkg::*;
#(
  parameter int PERIODS = CCS_PERIODS_PER_CYCLE
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Code memory
  input wire logic [7:0] code_data_i,
  output logic [15:0] code_addr_o,
  output logic code_fetch_o,
  output logic boot_rom_sel_o,
  output logic addr_latch_strobe_o,
  output logic ext_data_strobe_o,
  // Decoder and datapath
  input wire logic [3:0] op_class_i,
  input wire logic [7:0] acc_i,
  input wire logic carry_in_i,
  input wire logic half_carry_in_i,
  input wire logic srange_in_i,
  input wire logic [7:0] b_result_i,
  input wire logic boot_mode_i,
  input wire logic [2:0] reg_index_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] stack_addr_o,
  output logic [7:0] opcode_o,
  output logic [7:0] operand_o,
  output logic [7:0] b_reg_o,
  output logic instr_end_o
);

  // Elaboration check
  if (PERIODS != 12) begin : g_bad_periods
    $error("PERIODS must be 12");
  end

  // ==========================================================
  // Pin synchroniser for chip mode
  // ==========================================================
  logic mode_s1_r, mode_s2_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end else begin
      mode_s1_r <= boot_mode_i;
      mode_s2_r <= mode_s1_r;
    end
  end

  // ==========================================================
  // Machine cycle phase counter
  // ==========================================================
  logic [3:0] period_r, period_nxt;
  logic [2:0] cyc_r, cyc_nxt;
  logic [2:0] cyc_total_r, cyc_total_nxt;
  ccs_op_t op_r, op_nxt;
  logic two_byte_r, two_byte_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] opcode_r, opcode_nxt;
  logic [7:0] operand_r, operand_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] sp_r, sp_nxt;
  logic [7:0] b_r, b_nxt;
  logic [7:0] stack_addr_r, stack_addr_nxt;
  logic strobe_r, strobe_nxt;
  logic [7:0] acc_r, acc_nxt;

  // Period index 0..11 is S1P1..S6P2
  localparam logic [3:0] P_S1P2 = 4'h1;
  localparam logic [3:0] P_S2P2 = 4'h3;
  localparam logic [3:0] P_S4P1 = 4'h6;
  localparam logic [3:0] P_S4P2 = 4'h7;
  localparam logic [3:0] P_S5P2 = 4'h9;
  localparam logic [3:0] P_S6P2 = 4'hB;

  logic last_period, last_cycle, ext_cycle, fetch1, fetch2;
  logic apb_wr, apb_access;
  logic [7:0] wbyte;

  assign apb_access = psel_i && penable_i;
  assign apb_wr = apb_access && pwrite_i && pstrb_i[0];
  assign wbyte = pwdata_i[7:0];

  always_comb begin
    last_period = (period_r == P_S6P2);
    last_cycle = (cyc_r == cyc_total_r - 3'h1);
    // Second cycle of an external move owns the bus
    ext_cycle = (op_r == CCS_OP_EXT_MOVE) && (cyc_r == 3'h1);
    fetch1 = (period_r == P_S1P2) && !ext_cycle;
    fetch2 = (period_r == P_S4P2) && !ext_cycle;
  end

  always_comb begin
    period_nxt = last_period ? 4'h0 : period_r + 4'h1;
    cyc_nxt = cyc_r;
    cyc_total_nxt = cyc_total_r;
    op_nxt = op_r;
    two_byte_nxt = two_byte_r;
    pc_nxt = pc_r;
    opcode_nxt = opcode_r;
    operand_nxt = operand_r;
    acc_nxt = acc_r;
    // Registered, so set one period early: high through S1P2-S2P1 and S4P2-S5P1
    strobe_nxt = (period_r == 4'h0) || (period_r == P_S1P2)
      || (period_r == P_S4P1) || (period_r == P_S4P2);
    if (ext_cycle) begin
      strobe_nxt = 1'b0;
    end
    if (last_period) begin
      cyc_nxt = last_cycle ? 3'h0 : cyc_r + 3'h1;
    end
    if (fetch1 && cyc_r == 3'h0) begin
      opcode_nxt = code_data_i;
      op_nxt = ccs_op_t'(op_class_i);
      pc_nxt = pc_r + 16'h0001;
      two_byte_nxt = (ccs_op_t'(op_class_i) == CCS_OP_PLAIN2);
      case (ccs_op_t'(op_class_i))
        CCS_OP_PRODUCT, CCS_OP_QUOTIENT: cyc_total_nxt = 3'(CCS_CYC_PRODUCT);
        CCS_OP_EXT_MOVE: cyc_total_nxt = 3'(CCS_CYC_EXT_MOVE);
        CCS_OP_LONG1: cyc_total_nxt = 3'(CCS_CYC_LONG);
        default: cyc_total_nxt = 3'h1;
      endcase
    end
    if (fetch2) begin
      if (two_byte_r && cyc_r == 3'h0) begin
        operand_nxt = code_data_i;
        pc_nxt = pc_r + 16'h0001;
      end
      // Otherwise the byte is dropped and the PC holds
    end
    // Accumulator snapshot in phase 2 transfer slot
    if (period_r == P_S5P2) begin
      acc_nxt = acc_i;
    end
  end

  // ==========================================================
  // Status word, stack pointer, B register
  // ==========================================================
  logic sp_hit, st_hit, b_hit, acc_hit, seq_hit, hit;
  always_comb begin
    st_hit = paddr_i == CCS_OFS_STATUS;
    sp_hit = paddr_i == CCS_OFS_STACK;
    b_hit = paddr_i == CCS_OFS_BREG;
    acc_hit = paddr_i == CCS_OFS_ACC;
    seq_hit = paddr_i == CCS_OFS_SEQ;
    hit = st_hit || sp_hit || b_hit || acc_hit || seq_hit;
  end

  always_comb begin
    status_nxt = status_r;
    sp_nxt = sp_r;
    b_nxt = b_r;
    stack_addr_nxt = stack_addr_r;
    // Flags from ALU in phase 1 of S6, final cycle only
    if (period_r == P_S6P2 - 4'h1 && last_cycle) begin
      if (op_r == CCS_OP_ARITH || op_r == CCS_OP_DECIMAL) begin
        status_nxt[CCS_BIT_CARRY] = carry_in_i;
        status_nxt[CCS_BIT_SRANGE] = srange_in_i;
      end
      if (op_r == CCS_OP_DECIMAL) begin
        status_nxt[CCS_BIT_HALF] = half_carry_in_i;
      end
      if (op_r == CCS_OP_PRODUCT || op_r == CCS_OP_QUOTIENT) begin
        b_nxt = b_result_i;
        status_nxt[CCS_BIT_SRANGE] = srange_in_i;
      end
    end
    // Stack moves in phase 2 of S3 on the first cycle
    if (period_r == 4'h5 && cyc_r == 3'h0) begin
      case (op_r)
        CCS_OP_STACK_STORE, CCS_OP_SUB_ENTRY: begin
          sp_nxt = sp_r + 8'h01;
          stack_addr_nxt = sp_r + 8'h01;
        end
        CCS_OP_STACK_LOAD, CCS_OP_SUB_EXIT, CCS_OP_IRQ_EXIT: begin
          stack_addr_nxt = sp_r;
          sp_nxt = sp_r - 8'h01;
        end
        default: begin
        end
      endcase
    end
    // Software writes win over hardware updates, except the parity bit
    if (apb_wr && st_hit) begin
      status_nxt = wbyte;
    end
    if (apb_wr && sp_hit) begin
      sp_nxt = wbyte;
      // Stack address tracks the top byte after a software move too
      stack_addr_nxt = wbyte;
    end
    if (apb_wr && b_hit) begin
      b_nxt = wbyte;
    end
    // Parity always tracks the accumulator snapshot
    status_nxt[CCS_BIT_ODD] = ^acc_r;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      period_r <= 4'h0;
      cyc_r <= 3'h0;
      cyc_total_r <= 3'h1;
      op_r <= CCS_OP_PLAIN1;
      two_byte_r <= 1'b0;
      pc_r <= CCS_PC_RST;
      opcode_r <= 8'h00;
      operand_r <= 8'h00;
      acc_r <= 8'h00;
      strobe_r <= 1'b0;
      status_r <= CCS_STATUS_RST;
      sp_r <= CCS_STACK_RST;
      b_r <= 8'h00;
      stack_addr_r <= CCS_STACK_RST;
    end else begin
      period_r <= period_nxt;
      cyc_r <= cyc_nxt;
      cyc_total_r <= cyc_total_nxt;
      op_r <= op_nxt;
      two_byte_r <= two_byte_nxt;
      pc_r <= pc_nxt;
      opcode_r <= opcode_nxt;
      operand_r <= operand_nxt;
      acc_r <= acc_nxt;
      strobe_r <= strobe_nxt;
      status_r <= status_nxt;
      sp_r <= sp_nxt;
      b_r <= b_nxt;
      stack_addr_r <= stack_addr_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_comb begin
    code_addr_o = pc_r;
    code_fetch_o = fetch1 || fetch2;
    // Low 4K overlay, chip-mode chosen elsewhere
    boot_rom_sel_o = mode_s2_r && (pc_r <= CCS_OVERLAY_TOP);
    addr_latch_strobe_o = strobe_r;
    ext_data_strobe_o = ext_cycle;
    instr_end_o = last_period && last_cycle;
    reg_addr_o = {3'h0, status_r[CCS_BIT_BANK_HI], status_r[CCS_BIT_BANK_LO], reg_index_i};
    stack_addr_o = stack_addr_r;
    opcode_o = opcode_r;
    operand_o = operand_r;
    b_reg_o = b_r;
    pready_o = 1'b1;
    pslverr_o = apb_access && !hit;
    prdata_o = 32'h0000_0000;
    if (st_hit) prdata_o = {24'h0, status_r};
    if (sp_hit) prdata_o = {24'h0, sp_r};
    if (b_hit) prdata_o = {24'h0, b_r};
    if (acc_hit) prdata_o = {24'h0, acc_r};
    if (seq_hit) prdata_o = {24'h0, 1'b0, cyc_r, period_r};
  end

endmodule
`default_nettype wire

// ===== ccs_code_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Code memory model
module ccs_code_mem (
  input wire logic [15:0] addr_i,
  input wire logic fetch_i,
  output logic [7:0] data_o
);
  // Bus inverted when not fetched, so a stale byte never looks valid
  assign data_o = fetch_i ? (addr_i[7:0] ^ 8'h5A) : ~(addr_i[7:0] ^ 8'h5A);
endmodule
`default_nettype wire

// ===== ccs_cpu_cycle_status_stack_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checker
module ccs_cpu_cycle_status_stack_assertions
  import ccs_pkg::*;
#(
  parameter int PERIODS = CCS_PERIODS_PER_CYCLE
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [15:0] code_addr_o,
  input wire logic code_fetch_o,
  input wire logic boot_rom_sel_o,
  input wire logic addr_latch_strobe_o,
  input wire logic ext_data_strobe_o,
  input wire logic [2:0] reg_index_i,
  input wire logic [7:0] reg_addr_o,
  input wire logic [7:0] stack_addr_o,
  input wire logic instr_end_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  wire logic sp_wr = psel_i && penable_i && pwrite_i && paddr_i == CCS_OFS_STACK;
  strobe_width_a: assert property ($rose(addr_latch_strobe_o) |=> addr_latch_strobe_o ##1 !addr_latch_strobe_o)
    else $error("strobe width wrong");
  fetch_strobe_a: assert property (code_fetch_o |-> $rose(addr_latch_strobe_o))
    else $error("fetch off strobe");
  end_gap_a: assert property (instr_end_o |=> !instr_end_o [*8])
    else $error("end pulses too close");
  sp_reset_a: assert property ($fell(srst_i) |-> stack_addr_o == CCS_STACK_RST)
    else $error("stack reset value wrong");
  sp_step_a: assert property ($changed(stack_addr_o) && !$past(sp_wr) && !$past(srst_i) |->
    8'(stack_addr_o - $past(stack_addr_o)) inside {8'h01, 8'hFF})
    else $error("stack step wrong");
  bank_addr_a: assert property (reg_addr_o[2:0] == reg_index_i && reg_addr_o[7:5] == 3'h0)
    else $error("register address wrong");
  boot_win_a: assert property (boot_rom_sel_o |-> code_addr_o <= CCS_OVERLAY_TOP)
    else $error("boot select outside window");
  ext_quiet_a: assert property (ext_data_strobe_o |-> !code_fetch_o && !addr_latch_strobe_o)
    else $error("fetch during data move");
  apb_err_a: assert property (psel_i && penable_i |->
    pready_o && (pslverr_o == (paddr_i > CCS_OFS_SEQ || paddr_i[1:0] != 2'h0)))
    else $error("bus answer wrong");
  cover property (ext_data_strobe_o);
  cover property ($rose(boot_rom_sel_o));
  cover property (psel_i && penable_i && pslverr_o);
endmodule
bind ccs_cpu_cycle_status_stack ccs_cpu_cycle_status_stack_assertions #(.PERIODS(PERIODS)) chk (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .code_addr_o(code_addr_o),
  .code_fetch_o(code_fetch_o), .boot_rom_sel_o(boot_rom_sel_o), .addr_latch_strobe_o(addr_latch_strobe_o),
  .ext_data_strobe_o(ext_data_strobe_o), .reg_index_i(reg_index_i), .reg_addr_o(reg_addr_o),
  .stack_addr_o(stack_addr_o), .instr_end_o(instr_end_o));
`default_nettype wire

// ===== ccs_cpu_cycle_status_stack_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_cpu_cycle_status_stack_bench;
  import ccs_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, boot_mode_i = 1'b0;
  logic carry_in_i = 1'b0, half_carry_in_i = 1'b0, srange_in_i = 1'b0, err;
  logic [7:0] paddr_i = 8'h00, acc_i = 8'h00, b_result_i = 8'h00, code_data_i, reg_addr_o, stack_addr_o;
  logic [7:0] opcode_o, operand_o, b_reg_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] op_class_i = 4'h0;
  logic [2:0] reg_index_i = 3'h5;
  logic [15:0] code_addr_o, pc0;
  logic pready_o, pslverr_o, code_fetch_o, boot_rom_sel_o, addr_latch_strobe_o, ext_data_strobe_o, instr_end_o;
  int num_errors = 0, checked = 0, n, nf;
  ccs_op_t ops[6] = '{CCS_OP_PLAIN1, CCS_OP_PLAIN2, CCS_OP_LONG1, CCS_OP_EXT_MOVE, CCS_OP_PRODUCT, CCS_OP_QUOTIENT};
  int cyc[6] = '{1, 1, 2, 2, 4, 4};
  int len[6] = '{1, 2, 1, 1, 1, 1};
  ccs_op_t sops[5] = '{CCS_OP_STACK_STORE, CCS_OP_SUB_ENTRY, CCS_OP_STACK_LOAD, CCS_OP_SUB_EXIT, CCS_OP_IRQ_EXIT};
  logic [7:0] sexp[5] = '{8'h31, 8'h32, 8'h31, 8'h30, 8'h2F};
  ccs_cpu_cycle_status_stack #(.PERIODS(CCS_PERIODS_PER_CYCLE)) DUT (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .code_data_i(code_data_i),
    .code_addr_o(code_addr_o), .code_fetch_o(code_fetch_o), .boot_rom_sel_o(boot_rom_sel_o),
    .addr_latch_strobe_o(addr_latch_strobe_o), .ext_data_strobe_o(ext_data_strobe_o), .op_class_i(op_class_i),
    .acc_i(acc_i), .carry_in_i(carry_in_i), .half_carry_in_i(half_carry_in_i), .srange_in_i(srange_in_i),
    .b_result_i(b_result_i), .boot_mode_i(boot_mode_i), .reg_index_i(reg_index_i), .reg_addr_o(reg_addr_o),
    .stack_addr_o(stack_addr_o), .opcode_o(opcode_o), .operand_o(operand_o), .b_reg_o(b_reg_o),
    .instr_end_o(instr_end_o));
  ccs_code_mem mem (.addr_i(code_addr_o), .fetch_i(code_fetch_o), .data_o(code_data_i));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ====================
  // Bus and sequencing tasks, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Let an edge pass so a following call never re-drives psel in this step
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Next class goes in at an end pulse, plain one-byte class refills after it
  task automatic do_op(input ccs_op_t op);
    do @(posedge clk_i); while (instr_end_o !== 1'b1);
    op_class_i <= op;
    pc0 = code_addr_o;
    n = 0;
    nf = 0;
    do begin
      @(posedge clk_i);
      n++;
      nf += int'(code_fetch_o === 1'b1);
    end while (instr_end_o !== 1'b1 && n < 100);
    op_class_i <= CCS_OP_PLAIN1;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(CCS_OFS_STACK, 32'h07);
    for (int i = 0; i < 6; i++) begin
      do_op(ops[i]);
      check(n, 12 * cyc[i]);
      check(nf, (i == 3) ? 2 : 2 * cyc[i]);
      check(code_addr_o - pc0, len[i]);
      check(opcode_o, pc0[7:0] ^ 8'h5A);
      if (i == 1) check(operand_o, (pc0[7:0] + 8'h01) ^ 8'h5A);
    end
    apb(1'b1, CCS_OFS_STACK, 32'h30);
    rd_chk(CCS_OFS_STACK, 32'h30);
    for (int i = 0; i < 5; i++) begin
      do_op(sops[i]);
      rd_chk(CCS_OFS_STACK, sexp[i]);
    end
    acc_i <= 8'h07;
    carry_in_i <= 1'b1;
    srange_in_i <= 1'b1;
    half_carry_in_i <= 1'b1;
    b_result_i <= 8'hC3;
    do_op(CCS_OP_ARITH);
    rd_chk(CCS_OFS_STATUS, 32'h85);
    do_op(CCS_OP_DECIMAL);
    rd_chk(CCS_OFS_STATUS, 32'hC5);
    do_op(CCS_OP_PRODUCT);
    check(b_reg_o, 8'hC3);
    b_result_i <= 8'h3C;
    acc_i <= 8'h03;
    do_op(CCS_OP_PLAIN1);
    check(b_reg_o, 8'hC3);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, CCS_OFS_STATUS, 32'(b * 8));
      @(posedge clk_i);
      check(reg_addr_o, 8 * b + 5);
    end
    rd_chk(CCS_OFS_STATUS, 32'h18);
    apb(1'b0, 8'h14, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    boot_mode_i <= 1'b1;
    do_op(CCS_OP_PLAIN1);
    check(boot_rom_sel_o, 1'b1);
    boot_mode_i <= 1'b0;
    do_op(CCS_OP_PLAIN1);
    check(boot_rom_sel_o, 1'b0);
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(CCS_OFS_STACK, 32'h07);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
